/* File: include/timer_output_map.vh */
// Register map and constants for the timer channel output control block.
// Assumes a 32-bit APB bus; every register takes one aligned word.
`ifndef TIMER_OUTPUT_MAP_VH
`define TIMER_OUTPUT_MAP_VH

`define ADDR_COMPARE 8'h00
`define ADDR_LEVELS 8'h04
`define ADDR_ENABLES 8'h08
`define ADDR_MODE 8'h0C
`define ADDR_STATUS 8'h10

`define COMPARE_RESET 16'h0000
`define LEVELS_RESET 4'h0
`define ENABLES_RESET 4'h0
`define MODE_RESET 2'h0

`define MODE_SQUARE 2'h0
`define MODE_PWM 2'h1
`define MODE_STOP 2'h2
`define MODE_MSB 1

`define RUN_BIT 2
`define ZERO_WORD 32'h00000000
`define COUNT_ONE 16'h0001

`endif

/* File: design/channel_counter.v */
// One down-counter for a timer channel, reloading from its compare value.
// Assumes the compare value comes from a register on the same clock.
`timescale 1ns/1ps
`include "timer_output_map.vh"

module channel_counter #(
	parameter WIDTH = 16
) (
	input wire clk,
	input wire rst,
	input wire run,
	input wire [WIDTH-1:0] reload,
	output reg [WIDTH-1:0] count_reg,
	output reg expire_reg
);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg <= {WIDTH{1'b0}};
			expire_reg <= 1'b0;
		end else if (!run) begin
			count_reg <= reload;
			expire_reg <= 1'b0;
		end else if (count_reg == {WIDTH{1'b0}}) begin
			count_reg <= reload;
			expire_reg <= 1'b1;
		end else begin
			count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
			expire_reg <= 1'b0;
		end
	end
endmodule // channel_counter

/* File: design/timer_channel_output_control.v */
// Output control for the channels of a timer array unit, with APB registers.
// Assumes a single clock domain; pins are driven straight from flip-flops.
`timescale 1ns/1ps
`include "timer_output_map.vh"

module timer_channel_output_control #(
	parameter CHANNELS = 4,
	parameter WIDTH = 16
) (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg [CHANNELS-1:0] channel_out
);
	// Bus answer states, one-hot: idle until a setup cycle, then one answering access cycle.
	localparam BUS_WAIT = 2'b01;
	localparam BUS_ANSWER = 2'b10;
	localparam DATA_BITS = 32;

	reg [1:0] bus_state_reg;
	reg [1:0] bus_state_next;
	reg [WIDTH-1:0] channel_compare_value_reg;
	reg [WIDTH-1:0] channel_compare_value_next;
	reg [CHANNELS-1:0] timer_output_levels_reg;
	wire [CHANNELS-1:0] timer_output_levels_next;
	reg [CHANNELS-1:0] timer_output_enables_reg;
	reg [CHANNELS-1:0] timer_output_enables_next;
	reg [1:0] mode_reg;
	reg [1:0] mode_next;
	reg pwm_phase_reg;
	reg pwm_phase_next;
	reg [31:0] read_next;
	reg [31:0] prdata_next;
	reg pready_next;
	reg pslverr_next;
	reg decode_ok;
	reg run;
	reg pwm_mode;
	wire [31:0] compare_word;
	wire [31:0] levels_word;
	wire [31:0] enables_word;
	wire [31:0] mode_word;
	wire [31:0] status_word;
	wire [WIDTH-1:0] count;
	wire expire;
	wire setup;
	wire access;
	wire wr;
	wire rd_setup;
	wire wr_compare;
	wire wr_levels;
	wire wr_enables;
	wire wr_mode;
	genvar ch;

	assign setup = psel && !penable;
	// A write lands only at the edge where the master samples pready, so nothing is committed early.
	assign access = psel && penable && pready;
	assign wr = access && pwrite;
	assign rd_setup = setup && !pwrite;
	assign wr_compare = wr && (paddr == `ADDR_COMPARE);
	assign wr_levels = wr && (paddr == `ADDR_LEVELS);
	assign wr_enables = wr && (paddr == `ADDR_ENABLES);
	assign wr_mode = wr && (paddr == `ADDR_MODE);

	assign compare_word = {{(DATA_BITS-WIDTH){1'b0}}, channel_compare_value_reg};
	assign levels_word = {{(DATA_BITS-CHANNELS){1'b0}}, timer_output_levels_reg};
	assign enables_word = {{(DATA_BITS-CHANNELS){1'b0}}, timer_output_enables_reg};
	assign mode_word = {{(DATA_BITS-`MODE_MSB-1){1'b0}}, mode_reg};
	assign status_word = {{(DATA_BITS-WIDTH){1'b0}}, count};

	channel_counter #(
		.WIDTH(WIDTH)
	) counter_inst (
		.clk(clk),
		.rst(rst),
		.run(run),
		.reload(channel_compare_value_reg),
		.count_reg(count),
		.expire_reg(expire)
	);

	// Mode decode; the spare code counts like square wave so a stray value never freezes a pin.
	always @* begin
		run = 1'b1;
		pwm_mode = 1'b0;
		case (mode_reg)
			`MODE_SQUARE: begin
				run = 1'b1;
				pwm_mode = 1'b0;
			end
			`MODE_PWM: begin
				run = 1'b1;
				pwm_mode = 1'b1;
			end
			`MODE_STOP: begin
				run = 1'b0;
				pwm_mode = 1'b0;
			end
			default: begin
				run = 1'b1;
				pwm_mode = 1'b0;
			end
		endcase
	end

	// Address decode for the implemented words.
	always @* begin
		decode_ok = 1'b1;
		read_next = `ZERO_WORD;
		case (paddr)
			`ADDR_COMPARE: begin
				read_next = compare_word;
			end
			`ADDR_LEVELS: begin
				read_next = levels_word;
			end
			`ADDR_ENABLES: begin
				read_next = enables_word;
			end
			`ADDR_MODE: begin
				read_next = mode_word;
			end
			`ADDR_STATUS: begin
				read_next = status_word;
			end
			default: begin
				decode_ok = 1'b0;
			end
		endcase
	end

	// Bus answer sequencing.
	always @* begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			BUS_WAIT: begin
				if (setup) begin
					bus_state_next = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				bus_state_next = BUS_WAIT;
			end
			default: begin
				bus_state_next = BUS_WAIT;
			end
		endcase
	end

	// Read data is captured at setup and then held, so it stays valid until the next read.
	always @* begin
		pready_next = (bus_state_next == BUS_ANSWER);
		pslverr_next = (bus_state_next == BUS_ANSWER) && !decode_ok;
		prdata_next = prdata;
		if (rd_setup && (bus_state_reg == BUS_WAIT)) begin
			prdata_next = read_next;
		end
	end

	always @* begin
		channel_compare_value_next = channel_compare_value_reg;
		if (wr_compare) begin
			channel_compare_value_next = pwdata[WIDTH-1:0];
		end
	end

	always @* begin
		timer_output_enables_next = timer_output_enables_reg;
		if (wr_enables) begin
			timer_output_enables_next = pwdata[CHANNELS-1:0];
		end
	end

	always @* begin
		mode_next = mode_reg;
		if (wr_mode) begin
			mode_next = pwdata[`MODE_MSB:0];
		end
	end

	// PWM phase alternates high and low periods of the compare interval.
	always @* begin
		pwm_phase_next = pwm_phase_reg;
		if (expire) begin
			pwm_phase_next = ~pwm_phase_reg;
		end
	end

	// Per-channel level update; a bus write only reaches disabled channels.
	generate
		for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : channel_slot
			reg slot_next;
			wire slot_enabled;
			wire slot_event_level;
			assign slot_enabled = timer_output_enables_reg[ch];
			assign slot_event_level = pwm_mode ? ~pwm_phase_reg : ~timer_output_levels_reg[ch];
			always @* begin
				slot_next = timer_output_levels_reg[ch];
				if (slot_enabled) begin
					if (expire) begin
						slot_next = slot_event_level;
					end
				end else if (wr_levels) begin
					slot_next = pwdata[ch];
				end
			end
			assign timer_output_levels_next[ch] = slot_next;
		end
	endgenerate

	// Bus answer registers.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_state_reg <= BUS_WAIT;
		end else begin
			bus_state_reg <= bus_state_next;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= pready_next;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= pslverr_next;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= `ZERO_WORD;
		end else begin
			prdata <= prdata_next;
		end
	end

	// Control registers.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			channel_compare_value_reg <= `COMPARE_RESET;
		end else begin
			channel_compare_value_reg <= channel_compare_value_next;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_output_enables_reg <= `ENABLES_RESET;
		end else begin
			timer_output_enables_reg <= timer_output_enables_next;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_reg <= `MODE_RESET;
		end else begin
			mode_reg <= mode_next;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pwm_phase_reg <= 1'b0;
		end else begin
			pwm_phase_reg <= pwm_phase_next;
		end
	end

	// Channel levels and pins share one next value, so a pin never lags its level bit.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_output_levels_reg <= `LEVELS_RESET;
			channel_out <= {CHANNELS{1'b0}};
		end else begin
			timer_output_levels_reg <= timer_output_levels_next;
			channel_out <= timer_output_levels_next;
		end
	end
endmodule // timer_channel_output_control

/* File: testbench/timer_output_chk.sv */
// Assertions on the bus answers and channel pins of the output control block.
// Assumes it is bound into the block and sees only its ports.
`timescale 1ns/1ps
module timer_output_chk #(
	parameter CHANNELS = 4
) (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [CHANNELS-1:0] channel_out
);
	// Shadows of the enables and of a stopped counter, so pin checks know who drives each pin.
	reg [CHANNELS-1:0] en_reg;
	reg stop_reg;
	wire wr = psel && penable && pready && pwrite;
	always @(posedge clk or posedge rst) begin
		if (rst)
			stop_reg <= 1'b0;
		else if (wr && paddr == 8'h0C)
			stop_reg <= (pwdata[1:0] == 2'h2);
	end
	always @(posedge clk or posedge rst) begin
		if (rst)
			en_reg <= {CHANNELS{1'b0}};
		else if (wr && paddr == 8'h08)
			en_reg <= pwdata[CHANNELS-1:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_write_lands: assert property (
		wr && paddr == 8'h04 && ~|en_reg |=> channel_out == $past(pwdata[CHANNELS-1:0]))
		else $error("level write missed the pins");
	a_pin_holds: assert property (
		~|en_reg && !(wr && (paddr == 8'h04 || paddr == 8'h08)) |=> $stable(channel_out))
		else $error("pins moved without a write");
	a_read_level: assert property (
		pready && !pwrite && paddr == 8'h04 && ~|en_reg |-> prdata[CHANNELS-1:0] == channel_out)
		else $error("level read differs from pins");
	a_high_zero: assert property (
		pready && !pwrite && (paddr == 8'h04 || paddr == 8'h08) |-> prdata[31:CHANNELS] == 0)
		else $error("upper bits not zero");
	a_pready_pulse: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("pready not a one cycle answer");
	a_unmapped_err: assert property (
		psel && !penable && !pwrite && paddr > 8'h10 |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_enabled_hold: assert property (
		stop_reg && $past(stop_reg) && wr && paddr == 8'h04 |=> (channel_out & en_reg) == ($past(channel_out) & en_reg))
		else $error("write reached an enabled level bit");
endmodule // timer_output_chk

/* File: testbench/tb.sv */
// Bench for the output control block, driving APB transfers.
// Assumes the block answers every transfer and mode code 2 stops counting.
`timescale 1ns/1ps
module tb;
	reg clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, rd, er;
	wire [31:0] prdata;
	wire pready, pslverr;
	wire [3:0] channel_out;
	integer num_errors = 0, cmp_count = 0, n;
	always #20 clk = ~clk;
	timer_channel_output_control dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .channel_out);
	task xfer(input [7:0] a, input w, input [31:0] d);
		begin
			@(posedge clk);
			psel <= 1;
			penable <= 0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1;
			do begin
				@(posedge clk);
			end while (pready !== 1'b1);
			rd = prdata;
			er = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask
	task chk(input [31:0] s, input [31:0] e);
		begin
			cmp_count++;
			if (s !== e) begin
				num_errors++;
				$display("[ERR] %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		xfer(a, 1, d);
	endtask
	task rc(input [7:0] a, input [31:0] e);
		begin
			xfer(a, 0, 0);
			chk(rd, e);
		end
	endtask
	task print_verdict;
		begin
			$display("compares %0d mismatches %0d", cmp_count, num_errors);
			if (num_errors == 0 && cmp_count > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Counting is held for the static test, so the pins only move by writes.
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		rc(8'h08, 32'h0);
		wr(8'h0C, 32'h2);
		rc(8'h0C, 32'h2);
		wr(8'h04, 32'hFFFFFFFF);
		rc(8'h04, 32'hF);
		wr(8'h04, 32'h3);
		@(posedge clk);
		chk(channel_out, 4'h3);
		wr(8'h08, 32'hFFFFFFF5);
		rc(8'h08, 32'h5);
		wr(8'h04, 32'hF);
		@(posedge clk);
		chk(channel_out, 4'hB);
		xfer(8'h20, 0, 0);
		chk(er, 1);
		$display("static test done");
		wr(8'h00, 32'h3);
		rc(8'h00, 32'h3);
		wr(8'h0C, 32'h0);
		n = 0;
		while (channel_out === 4'hB && n < 50) begin @(posedge clk); n++; end
		chk(channel_out, 4'hE);
		n = 0;
		do begin @(posedge clk); n++; end while (channel_out === 4'hE && n < 50);
		chk(n, 4);
		$display("count test done");
		wr(8'h0C, 32'h1);
		repeat (12) @(posedge clk);
		chk(channel_out[0] ^ channel_out[2], 32'h0);
		chk(channel_out & 4'hA, 4'hA);
		wr(8'h04, 32'h0);
		@(posedge clk);
		chk(channel_out[0] ^ channel_out[2], 32'h0);
		chk(channel_out & 4'hA, 4'h0);
		$display("pwm test done");
		@(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk(channel_out, 4'h0);
		rc(8'h08, 32'h0);
		rc(8'h0C, 32'h0);
		$display("reset test done");
		print_verdict;
	end
	initial begin
		#200000;
		num_errors++;
		print_verdict;
	end
endmodule // tb
bind timer_channel_output_control timer_output_chk #(.CHANNELS(CHANNELS)) chk_i (.clk, .rst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .channel_out);
